// ===== hw/csr_slot_router.v
// Serial audio slot router between the link lines and the converter words.
`timescale 1ns/10ps
`include "csr_regs.vh"

module csr_slot_router (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_bit_clk,
	input wire i_frame_sync,
	input wire i_serial_in_line_a,
	input wire i_serial_in_line_b,
	input wire [1:0] i_format,
	input wire i_output_chain_enable,
	input wire [2:0] i_dac_slot_group_select,
	input wire [23:0] i_analog_input_one,
	input wire [23:0] i_analog_input_two,
	input wire [23:0] i_analog_input_three,
	input wire [23:0] i_analog_input_four,
	output wire o_serial_out_line_a,
	output wire o_serial_out_line_b,
	output wire [23:0] o_dac_word_one,
	output wire [23:0] o_dac_word_two,
	output wire [23:0] o_dac_word_three,
	output wire [23:0] o_dac_word_four,
	output wire o_dac_valid
);
	// ********************************************************
	// Helpers
	// ********************************************************
	// Position within the frame, shifted by one clock in I2S; bit 9 marks
	// the idle clock before the first data bit.
	function [9:0] eff_pos;
		input [8:0] p;
		input i2s;
		begin
			eff_pos = i2s ? ({1'b0, p} - 10'h001) : {1'b0, p};
		end
	endfunction

	// Slot bit b, MSB first.
	function word_bit;
		input [31:0] w;
		input [4:0] b;
		begin
			word_bit = w[`CSR_SLOT_LAST - b];
		end
	endfunction

	// Converter word n of a packed set of four.
	function [23:0] adc_word;
		input [95:0] a;
		input [1:0] n;
		begin
			adc_word = a[n*24 +: 24];
		end
	endfunction

	// ********************************************************
	// Pin sampling
	// ********************************************************
	wire [3:0] pin_s;
	csr_pin_sync #(.W(4)) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_serial_in_line_b, i_serial_in_line_a, i_frame_sync,
			i_bit_clk}),
		.o_sync(pin_s)
	);
	wire sclk_s = pin_s[0];
	wire fs_s = pin_s[1];
	wire din_a = pin_s[2];
	wire din_b = pin_s[3];

	reg sclk_q;
	reg fs_fall_q;
	reg [8:0] pos_q;
	reg [31:0] sh_a_q;
	reg [31:0] sh_b_q;
	reg [31:0] chain_mem [0:`CSR_CHAIN_DEPTH-1];
	reg [95:0] adc_h_q;
	reg [95:0] dac_q;
	reg out_a_q;
	reg out_b_q;
	reg valid_q;
	integer i;

	// ********************************************************
	// Edge detector arming
	// ********************************************************
	// The synchroniser and the edge register leave reset at zero while an
	// idle bit clock may sit high; edges are ignored until both hold real
	// pin levels, so no false edge follows reset.
	reg [1:0] arm_q;
	wire armed = (arm_q == `CSR_ARM_DONE);

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			arm_q <= `CSR_ARM_ZERO;
		end else if (!armed) begin
			arm_q <= arm_q + `CSR_ARM_STEP;
		end
	end

	wire rise = armed & sclk_s & ~sclk_q;
	wire fall = armed & ~sclk_s & sclk_q;
	wire tdm = (i_format == `CSR_MODE_TDM);
	wire i2s = (i_format == `CSR_MODE_I2S);
	wire left = i2s ? ~fs_s : fs_s;

	// ********************************************************
	// Transmit side, updated on falling bit clock edges
	// ********************************************************
	// Frames start on a frame sync rise in TDM, on any edge otherwise.
	wire new_frame = tdm ? (fs_s & ~fs_fall_q) : (fs_s ^ fs_fall_q);
	wire [8:0] pos_n = new_frame ? `CSR_POS_ZERO : (pos_q + `CSR_POS_STEP);
	wire [9:0] ep_n = eff_pos(pos_n, i2s);
	wire [3:0] slot_n = ep_n[8:5];
	wire [4:0] bit_n = ep_n[4:0];
	// Converter words are held for a whole frame so that a change mid-slot
	// cannot tear a word; the first bit uses the fresh value directly.
	wire latch = new_frame & (tdm | left);
	wire [95:0] adc_now = latch ? {i_analog_input_four,
		i_analog_input_three, i_analog_input_two, i_analog_input_one} :
		adc_h_q;
	wire [3:0] chain_idx = slot_n - `CSR_ADC_SLOTS;
	reg tx_a;
	reg tx_b;

	always @* begin
		tx_a = 1'b0;
		tx_b = 1'b0;
		if (!ep_n[9]) begin
			if (tdm) begin
				if (slot_n < `CSR_ADC_SLOTS) begin
					tx_a = word_bit({adc_word(adc_now, slot_n[1:0]),
						`CSR_PAD}, bit_n);
				end else if (i_output_chain_enable) begin
					tx_a = word_bit(chain_mem[chain_idx], bit_n);
				end
			end else if (slot_n == 4'h0) begin
				tx_a = word_bit({adc_word(adc_now, {1'b0, ~left}),
					`CSR_PAD}, bit_n);
				tx_b = word_bit({adc_word(adc_now, {1'b1, ~left}),
					`CSR_PAD}, bit_n);
			end
		end
	end

	// ********************************************************
	// Receive side, sampled on rising bit clock edges
	// ********************************************************
	wire [9:0] ep_r = eff_pos(pos_q, i2s);
	wire [3:0] slot_r = ep_r[8:5];
	wire [4:0] bit_r = ep_r[4:0];
	wire [31:0] word_a = {sh_a_q[30:0], din_a};
	wire [31:0] word_b = {sh_b_q[30:0], din_b};
	wire [31:0] sel_word = i_dac_slot_group_select[2] ? word_b : word_a;
	wire [1:0] grp = i_dac_slot_group_select[1:0];

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sclk_q <= 1'b0;
			fs_fall_q <= 1'b0;
			pos_q <= `CSR_POS_ZERO;
			sh_a_q <= 32'h00000000;
			sh_b_q <= 32'h00000000;
			adc_h_q <= 96'h0;
			dac_q <= 96'h0;
			out_a_q <= 1'b0;
			out_b_q <= 1'b0;
			valid_q <= 1'b0;
			for (i = 0; i < `CSR_CHAIN_DEPTH; i = i + 1) begin
				chain_mem[i] <= 32'h00000000;
			end
		end else begin
			sclk_q <= sclk_s;
			valid_q <= 1'b0;
			if (fall) begin
				fs_fall_q <= fs_s;
				pos_q <= pos_n;
				adc_h_q <= adc_now;
				out_a_q <= tx_a;
				out_b_q <= tx_b;
			end
			if (rise) begin
				sh_a_q <= word_a;
				sh_b_q <= word_b;
				if (!ep_r[9] && tdm && bit_r == `CSR_SLOT_LAST) begin
					chain_mem[slot_r] <= word_b;
					if (slot_r[3:2] == grp) begin
						dac_q[slot_r[1:0]*24 +: 24] <= sel_word[31:8];
						if (slot_r[1:0] == `CSR_GRP_LAST) begin
							valid_q <= 1'b1;
						end
					end
				end
				if (!ep_r[9] && !tdm && slot_r == 4'h0 &&
					bit_r == `CSR_WORD_LAST) begin
					if (left) begin
						dac_q[23:0] <= word_a[23:0];
						dac_q[71:48] <= word_b[23:0];
					end else begin
						dac_q[47:24] <= word_a[23:0];
						dac_q[95:72] <= word_b[23:0];
						valid_q <= 1'b1;
					end
				end
			end
		end
	end

	assign o_serial_out_line_a = out_a_q;
	assign o_serial_out_line_b = out_b_q;
	assign o_dac_word_one = dac_q[23:0];
	assign o_dac_word_two = dac_q[47:24];
	assign o_dac_word_three = dac_q[71:48];
	assign o_dac_word_four = dac_q[95:72];
	assign o_dac_valid = valid_q;
endmodule // csr_slot_router

// ===== hw/csr_regs.vh
// Constants shared by the serial slot router design files.
`ifndef CSR_REGS_VH
`define CSR_REGS_VH
`define CSR_MODE_TDM 2'h0
`define CSR_MODE_LJ 2'h1
`define CSR_MODE_I2S 2'h2
`define CSR_SLOT_LAST 5'h1F
`define CSR_WORD_LAST 5'h17
`define CSR_PAD 8'h00
`define CSR_ADC_SLOTS 4'h4
`define CSR_GRP_LAST 2'h3
`define CSR_POS_ZERO 9'h000
`define CSR_POS_STEP 9'h001
`define CSR_CHAIN_DEPTH 16
`define CSR_ARM_ZERO 2'h0
`define CSR_ARM_STEP 2'h1
`define CSR_ARM_DONE 2'h3
`endif

// ===== hw/csr_pin_sync.v
// Two-stage synchroniser for pins from outside the clock domain.
`timescale 1ns/10ps
module csr_pin_sync #(
	parameter W = 4
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire [W-1:0] i_async,
	output wire [W-1:0] o_sync
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule // csr_pin_sync

// ===== dv/csr_slot_router_sva.sv
// Checker on the slot router ports.
`timescale 1ns/10ps
module csr_slot_router_sva (
	input wire i_clk, i_rst_n, i_bit_clk,
	input wire [1:0] i_format,
	input wire o_serial_out_line_a, o_serial_out_line_b, o_dac_valid,
	input wire [23:0] o_dac_word_one, o_dac_word_two,
	input wire [23:0] o_dac_word_three, o_dac_word_four
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_rise;
		$past(i_bit_clk, 3) || $past(i_bit_clk, 4);
	endsequence
	property p_gap; o_dac_valid |=> !o_dac_valid [*8]; endproperty
	a_gap: assert property (p_gap) else $error("valid twice");
	property p_vedge; o_dac_valid |-> s_rise; endproperty
	a_vedge: assert property (p_vedge) else $error("valid early");
	property p_four; !$stable(o_dac_word_four) |-> o_dac_valid; endproperty
	a_four: assert property (p_four) else $error("word four");
	property p_one; !$stable(o_dac_word_one) |-> !o_dac_valid; endproperty
	a_one: assert property (p_one) else $error("word one");
	property p_three; !$stable(o_dac_word_three) |-> s_rise; endproperty
	a_three: assert property (p_three) else $error("word three");
	property p_two;
		!$stable(o_dac_word_two) |-> o_dac_valid == (i_format != 2'h0);
	endproperty
	a_two: assert property (p_two) else $error("word two");
	property p_out; !$stable(o_serial_out_line_a) |-> !$past(i_bit_clk, 3);
	endproperty
	a_out: assert property (p_out) else $error("line a timing");
	property p_bq; (i_format == 2'h0) [*8] |-> !o_serial_out_line_b;
	endproperty
	a_bq: assert property (p_bq) else $error("line b busy");
endmodule // csr_slot_router_sva

// ===== dv/csr_host_model.sv
// Host model: link clock, frame sync and serial lines of the far side.
`timescale 1ns/10ps
module csr_host_model (
	output logic o_bclk,
	output logic o_fs,
	output logic o_da,
	output logic o_db,
	input wire logic i_oa,
	input wire logic i_ob
);
	event got;
	logic [63:0] r;
	logic k;
	initial {o_bclk, o_fs, o_da, o_db} = 4'hA;
	// A line outside its word inverts so stale data is never mistaken.
	task automatic frame(input logic [1:0] f, input logic [23:0] sa, sb);
		int n, p, s;
		n = f == 2'h0 ? 512 : 64;
		for (int g = -1; g <= n; g++) begin
			s = g / 32;
			p = g % 32 - int'(f == 2'h2);
			o_fs = (g >= 0 && g < (n == 512 ? 4 : 32)) ^ (f == 2'h2);
			#100;
			if (g > 0) r = {r[62:32], i_oa, r[30:0], i_ob};
			if (g > 0 && g % 32 == 0) ->got;
			k = g >= 0 && g < n && p >= 0;
			o_bclk = 0;
			o_da = k ? {sa + 24'(s), 8'hC3} >> 31 - p : ~o_da;
			o_db = k ? {sb + 24'(s), 8'h3C} >> 31 - p : ~o_db;
			#300 o_bclk = 1;
			#400;
		end
	endtask
endmodule // csr_host_model

// ===== dv/csr_slot_router_tb_top.sv
// Self-checking bench for the slot router.
`timescale 1ns/10ps
module csr_slot_router_tb_top;
	logic i_clk = 0, i_rst_n = 0, i_output_chain_enable = 0;
	logic [1:0] i_format = 0;
	logic [2:0] i_dac_slot_group_select = 0;
	logic [23:0] ad [4] = '{4{24'h0}};
	wire i_bit_clk, i_frame_sync, i_serial_in_line_a, i_serial_in_line_b;
	wire o_serial_out_line_a, o_serial_out_line_b, o_dac_valid;
	wire [23:0] o_dac_word_one, o_dac_word_two;
	wire [23:0] o_dac_word_three, o_dac_word_four;
	wire [95:0] w = {o_dac_word_one, o_dac_word_two, o_dac_word_three,
		o_dac_word_four};
	logic [95:0] ql [$], qd [$], e;
	int errors = 0, n_compared = 0;
	csr_slot_router u_csr_slot_router (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_bit_clk(i_bit_clk), .i_frame_sync(i_frame_sync),
		.i_serial_in_line_a(i_serial_in_line_a),
		.i_serial_in_line_b(i_serial_in_line_b), .i_format(i_format),
		.i_output_chain_enable(i_output_chain_enable),
		.i_dac_slot_group_select(i_dac_slot_group_select),
		.o_serial_out_line_a(o_serial_out_line_a),
		.o_serial_out_line_b(o_serial_out_line_b),
		.o_dac_word_one(o_dac_word_one), .o_dac_word_two(o_dac_word_two),
		.o_dac_word_three(o_dac_word_three),
		.o_dac_word_four(o_dac_word_four), .o_dac_valid(o_dac_valid),
		.i_analog_input_one(ad[0]),
		.i_analog_input_two(ad[1]), .i_analog_input_three(ad[2]),
		.i_analog_input_four(ad[3]));
	csr_host_model u_csr_host_model (.o_bclk(i_bit_clk),
		.o_fs(i_frame_sync), .o_da(i_serial_in_line_a),
		.o_db(i_serial_in_line_b), .i_oa(o_serial_out_line_a),
		.i_ob(o_serial_out_line_b));
	initial forever #50 i_clk = ~i_clk;
	task automatic chk(input logic [95:0] x, y);
		n_compared++;
		if (x !== y) begin
			errors++;
			$display("wrong value at %0t: %h %h", $time, x, y);
		end
	endtask
	always @(u_csr_host_model.got)
		chk(ql.pop_front(), u_csr_host_model.r);
	always @(posedge i_clk)
		if (o_dac_valid === 1'b1) chk(qd.pop_front(), w);
	task automatic run(input logic [1:0] f, input logic c, input logic [2:0] k);
		logic [23:0] a, b;
		a = $urandom;
		b = $urandom;
		foreach (ad[j]) ad[j] = $urandom;
		{i_format, i_output_chain_enable, i_dac_slot_group_select} = {f, c, k};
		for (int s = 0; s < (f == 2'h0 ? 16 : 2); s++)
			ql.push_back(f == 2'h0 ? {s < 4 ? {ad[s], 8'h0} : c ?
				{b + 24'(s - 4), 8'h3C} : 32'h0, 32'h0} :
				{{ad[s], 8'h0} >> (f == 2'h2), {ad[s + 2], 8'h0} >> (f == 2'h2)});
		for (int j = 0; j < 4; j++)
			e = {e[71:0], (k[2] ? b : a) + 24'(4 * k[1:0] + j)};
		qd.push_back(f == 2'h0 ? e : {a, a + 24'h1, b, b + 24'h1});
		u_csr_host_model.frame(f, a, b);
		$display("test fmt %0d sel %0d chain %0d done", f, k, c);
	endtask
	task automatic finish_test;
		$display("compared %0d mismatched %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		void'($urandom(45));
		repeat (5) @(posedge i_clk);
		#2 i_rst_n = 1;
		for (int k = 0; k < 8; k++) run(2'h0, k[0], k[2:0]);
		run(2'h1, 1'b0, 3'h0);
		run(2'h2, 1'b1, 3'h0);
		repeat (20) @(posedge i_clk);
		chk(96'(ql.size() + qd.size()), 96'h0);
		finish_test;
	end
	initial begin
		#5000000 errors++;
		finish_test;
	end
endmodule // csr_slot_router_tb_top
bind csr_slot_router csr_slot_router_sva u_csr_slot_router_sva (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bit_clk(i_bit_clk),
	.i_format(i_format), .o_serial_out_line_a(o_serial_out_line_a),
	.o_serial_out_line_b(o_serial_out_line_b), .o_dac_valid(o_dac_valid),
	.o_dac_word_one(o_dac_word_one), .o_dac_word_two(o_dac_word_two),
	.o_dac_word_three(o_dac_word_three),
	.o_dac_word_four(o_dac_word_four));
